// ---- src/cbbse_top.sv ----
// cbbse_top: executes bit-carry, branch, system control and block copy
// instructions written over AXI4-Lite; holds a small byte memory for copies
// assumes one clock and a synchronous active-low reset
// Functional notes
// - carry becomes carry xor selected operand bit
// - carry becomes carry xor inverted bit; bit number is 3-bit immediate
// - selected operand bit copied to carry, operand unchanged
// - inverted selected bit copied to carry, bit number immediate
// - carry written into selected bit, other bits of byte kept
// - inverted carry written into selected bit, bit number immediate
// - branch taken only when condition true, else next instruction
// - conditions from N, Z, V, C as the sixteen condition codes
// - jump loads program counter with target unconditionally
// - relative and absolute calls save return location then jump
// - return restores saved return address to program counter
// - trap starts exception, vector chosen by immediate bits
// - exception return restores state saved on exception entry
// - sleep enters power-down state
// - load-control writes operand or immediate to either control register; code loads only from the extension word
// - store-control copies a control register out to register or memory; code writes only the store register
// - control registers move as words, value in upper 8 bits
// - and/or/xor control combine register with byte immediate
// - no-operation only advances program counter by two
// - block copy moves bytes, bumps pointers, counts down; zero copies none
// - next instruction accepted only after whole copy completes
// - instructions are handled as 16-bit units with op, reg, ea, cc
// - each copied byte post-increments both pointers by one
// - operation field always in top four bits of first word
//
// Implementation choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module cbbse_top
  import cbbse_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address channel
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // write data channel
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // write response channel
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // read address channel
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  // read data channel
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic cond_true(input logic [3:0] cc,
                                     input logic [7:0] f);
    logic c, v, z, n, t;
    c = f[C_BIT];
    v = f[V_BIT];
    z = f[Z_BIT];
    n = f[N_BIT];
    case (cc[3:1])
      3'h0: t = 1'b1;
      3'h1: t = ~(c | z);
      3'h2: t = ~c;
      3'h3: t = ~z;
      3'h4: t = ~v;
      3'h5: t = ~n;
      3'h6: t = ~(n ^ v);
      default: t = ~(z | (n ^ v));
    endcase
    return cc[0] ? ~t : t;
  endfunction

  // bus side state
  logic aw_held, w_held;
  logic [ADDR_W-1:0] wa_q;
  logic [31:0] wd_q;
  logic [3:0] ws_q;
  // execution state
  cbbse_state_e state;
  logic [15:0] insn;
  logic [31:0] ext;
  logic [7:0] opnd;
  logic [PC_W-1:0] pc;
  logic [7:0] condition_code_reg, extended_control_reg;
  logic [15:0] count;
  logic [31:0] src, dst;
  logic [MEM_AW-1:0] maddr;
  logic [15:0] store;
  logic taken;
  logic [PC_W-1:0] link [4];
  logic [STACK_AW-1:0] sp;
  logic [PC_W-1:0] sav_pc;
  logic [7:0] sav_flags, sav_ext_ctl;
  logic [7:0] mem [MEM_DEPTH];

  // handshake and write qualification
  wire aw_hs = awvalid & awready;
  wire w_hs = wvalid & wready;
  wire ar_hs = arvalid & arready;
  wire do_wr = aw_held & w_held & ~bvalid;
  wire next_aw_held = (aw_held | aw_hs) & ~do_wr;
  wire next_w_held = (w_held | w_hs) & ~do_wr;
  wire next_bvalid = do_wr | (bvalid & ~bready);
  wire next_rvalid = ar_hs | (rvalid & ~rready);
  wire busy = (state == ST_COPY);

  // write address decode
  wire wa_insn = (wa_q == REG_INSN);
  wire wa_ext = (wa_q == REG_EXT);
  wire wa_opnd = (wa_q == REG_OPND);
  wire wa_pc = (wa_q == REG_PC);
  wire wa_ctl = (wa_q == REG_CTL);
  wire wa_cnt = (wa_q == REG_COUNT);
  wire wa_src = (wa_q == REG_SRC);
  wire wa_dst = (wa_q == REG_DST);
  wire wa_madr = (wa_q == REG_MADDR);
  wire wa_mdat = (wa_q == REG_MDATA);
  wire wa_known = wa_insn | wa_ext | wa_opnd | wa_pc | wa_ctl | wa_cnt |
                  wa_src | wa_dst | wa_madr | wa_mdat;
  // writes are refused while a copy runs
  wire wr_ok = do_wr & wa_known & ~busy;
  wire go = wr_ok & wa_insn;

  // decode of the newly written instruction unit
  wire [31:0] wr_val = merge(32'h0, wd_q, ws_q);
  wire [31:0] insn_m = merge({16'h0, insn}, wd_q, ws_q);
  wire [31:0] ctl_m = merge({16'h0, extended_control_reg,
                             condition_code_reg}, wd_q, ws_q);
  wire [31:0] cnt_m = merge({16'h0, count}, wd_q, ws_q);
  wire [15:0] new_insn = insn_m[15:0];
  wire [3:0] op = new_insn[OP_HI:OP_LO];
  wire [3:0] sub = new_insn[SUB_HI:SUB_LO];
  wire [2:0] bitno = new_insn[BITNO_HI:BITNO_LO];
  wire sel_ext = new_insn[SEL_EXTCTL];
  wire word_form = new_insn[WORD_FORM];
  wire opbit = opnd[bitno];
  wire carry = condition_code_reg[C_BIT];
  // carry result of the bit group
  wire bit_carry = (sub == carry_xor_bit_op) ? carry ^ opbit :
                   (sub == carry_xor_inv_bit_op) ? carry ^ ~opbit :
                   (sub == bit_to_carry_op) ? opbit : ~opbit;
  wire uses_ext = (op == OP_BRANCH) | (op == OP_JUMP) | (op == OP_RCALL) |
                  (op == OP_ACALL) | (op == OP_LDCTL) | (op == OP_ANDCTL) |
                  (op == OP_ORCTL) | (op == OP_XORCTL);
  wire [PC_W-1:0] pc_next = pc + (uses_ext ? EXT_BYTES : UNIT_BYTES);
  wire cond = cond_true(sub, condition_code_reg);
  wire [7:0] ctl_cur = sel_ext ? extended_control_reg : condition_code_reg;
  wire [7:0] ctl_res = (op == OP_ANDCTL) ? ctl_cur & ext[7:0] :
                       (op == OP_ORCTL) ? ctl_cur | ext[7:0] :
                       ctl_cur ^ ext[7:0];
  wire [7:0] ld_val = word_form ? ext[15:8] : ext[7:0];
  wire [7:0] trap_va = TRAP_VEC_BASE + {4'h0, new_insn[TRAP_HI:TRAP_LO],
                       2'h0};
  wire [PC_W-1:0] trap_pc = {mem[trap_va + 8'h01], mem[trap_va + 8'h02],
                             mem[trap_va + 8'h03]};
  wire [15:0] cnt_eff = sub[0] ? count : {8'h0, count[7:0]};
  // a running copy takes its count width from the latched instruction,
  // since refused writes during the copy overwrite the write data holder
  wire word_cnt = insn[SUB_LO];
  wire [15:0] cnt_dec = count - 16'h0001;
  wire last_byte = word_cnt ? (cnt_dec == 16'h0) : (cnt_dec[7:0] == 8'h0);

  // read address decode
  wire ra_insn = (araddr == REG_INSN);
  wire ra_ext = (araddr == REG_EXT);
  wire ra_opnd = (araddr == REG_OPND);
  wire ra_pc = (araddr == REG_PC);
  wire ra_ctl = (araddr == REG_CTL);
  wire ra_st = (araddr == REG_STATUS);
  wire ra_cnt = (araddr == REG_COUNT);
  wire ra_src = (araddr == REG_SRC);
  wire ra_dst = (araddr == REG_DST);
  wire ra_madr = (araddr == REG_MADDR);
  wire ra_mdat = (araddr == REG_MDATA);
  wire ra_sto = (araddr == REG_STORE);
  wire [31:0] status_word = {29'h0, taken, state == ST_SLEEPING, busy};
  wire [31:0] rd_mux =
    ra_insn ? {16'h0, insn} :
    ra_ext ? ext :
    ra_opnd ? {24'h0, opnd} :
    ra_pc ? {8'h0, pc} :
    ra_ctl ? {16'h0, extended_control_reg, condition_code_reg} :
    ra_st ? status_word :
    ra_cnt ? {16'h0, count} :
    ra_src ? src :
    ra_dst ? dst :
    ra_madr ? {24'h0, maddr} :
    ra_mdat ? {24'h0, mem[maddr]} :
    ra_sto ? {16'h0, store} : 32'h0;
  wire ra_known = ra_insn | ra_ext | ra_opnd | ra_pc | ra_ctl | ra_st |
                  ra_cnt | ra_src | ra_dst | ra_madr | ra_mdat | ra_sto;

  // AXI4-Lite channel flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rresp <= RESP_OKAY;
      rdata <= 32'h0;
      wa_q <= 8'h0;
      wd_q <= 32'h0;
      ws_q <= 4'h0;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      awready <= ~next_aw_held & ~next_bvalid;
      wready <= ~next_w_held & ~next_bvalid;
      bvalid <= next_bvalid;
      arready <= ~next_rvalid;
      rvalid <= next_rvalid;
      if (aw_hs) begin
        wa_q <= awaddr;
      end
      if (w_hs) begin
        wd_q <= wdata;
        ws_q <= wstrb;
      end
      if (do_wr) begin
        bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (ar_hs) begin
        rdata <= rd_mux;
        rresp <= ra_known ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // byte memory: copy engine and bus window
  always_ff @(posedge aclk) begin
    if (busy) begin
      mem[dst[MEM_AW-1:0]] <= mem[src[MEM_AW-1:0]];
    end else if (wr_ok & wa_mdat & ws_q[0]) begin
      mem[maddr] <= wd_q[7:0];
    end
  end

  // instruction execution
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
      insn <= 16'h0;
      ext <= 32'h0;
      opnd <= 8'h0;
      pc <= 24'h0;
      condition_code_reg <= FLAGS_RESET;
      extended_control_reg <= EXTCTL_RESET;
      count <= 16'h0;
      src <= 32'h0;
      dst <= 32'h0;
      maddr <= 8'h0;
      store <= 16'h0;
      taken <= 1'b0;
      sp <= 2'h0;
      sav_pc <= 24'h0;
      sav_flags <= 8'h0;
      sav_ext_ctl <= 8'h0;
      for (int i = 0; i < 4; i++) begin
        link[i] <= 24'h0;
      end
    end else if (busy) begin
      src <= src + 32'h1;
      dst <= dst + 32'h1;
      if (word_cnt) begin
        count <= cnt_dec;
      end else begin
        count[7:0] <= cnt_dec[7:0];
      end
      if (last_byte) begin
        state <= ST_IDLE;
      end
    end else if (go) begin
      insn <= new_insn;
      pc <= pc_next;
      state <= ST_IDLE;
      taken <= 1'b0;
      case (op)
        OP_BIT: begin
          case (sub)
            carry_xor_bit_op, carry_xor_inv_bit_op, bit_to_carry_op,
            inv_bit_to_carry_op: begin
              condition_code_reg[C_BIT] <= bit_carry;
            end
            carry_to_bit_op: opnd[bitno] <= carry;
            inv_carry_to_bit_op: opnd[bitno] <= ~carry;
            default: ;
          endcase
        end
        OP_BRANCH: begin
          if (cond) begin
            pc <= ext[PC_W-1:0];
            taken <= 1'b1;
          end
        end
        OP_JUMP: pc <= ext[PC_W-1:0];
        OP_RCALL, OP_ACALL: begin
          link[sp] <= pc_next;
          sp <= sp + 2'h1;
          pc <= (op == OP_RCALL) ? pc_next + ext[PC_W-1:0] :
                ext[PC_W-1:0];
        end
        OP_RET: begin
          pc <= link[sp - 2'h1];
          sp <= sp - 2'h1;
        end
        OP_TRAP: begin
          sav_pc <= pc_next;
          sav_flags <= condition_code_reg;
          sav_ext_ctl <= extended_control_reg;
          condition_code_reg[I_BIT] <= 1'b1;
          pc <= trap_pc;
        end
        OP_ERET: begin
          pc <= sav_pc;
          condition_code_reg <= sav_flags;
          extended_control_reg <= sav_ext_ctl;
        end
        OP_SLEEP: state <= ST_SLEEPING;
        OP_LDCTL: begin
          if (sel_ext) begin
            extended_control_reg <= ld_val;
          end else begin
            condition_code_reg <= ld_val;
          end
        end
        OP_STCTL: begin
          store <= word_form ? {ctl_cur, 8'h0} : {8'h0, ctl_cur};
        end
        OP_ANDCTL, OP_ORCTL, OP_XORCTL: begin
          if (sel_ext) begin
            extended_control_reg <= ctl_res;
          end else begin
            condition_code_reg <= ctl_res;
          end
        end
        OP_COPY: begin
          if (cnt_eff != 16'h0) begin
            state <= ST_COPY;
          end
        end
        default: ;
      endcase
    end else if (wr_ok) begin
      if (wa_ext) ext <= merge(ext, wd_q, ws_q);
      if (wa_opnd) opnd <= wr_val[7:0];
      if (wa_pc) pc <= wr_val[PC_W-1:0];
      if (wa_ctl) begin
        condition_code_reg <= ctl_m[7:0];
        extended_control_reg <= ctl_m[15:8];
      end
      if (wa_cnt) count <= cnt_m[15:0];
      if (wa_src) src <= merge(src, wd_q, ws_q);
      if (wa_dst) dst <= merge(dst, wd_q, ws_q);
      if (wa_madr) maddr <= wr_val[MEM_AW-1:0];
    end
  end

endmodule
`default_nettype wire

// ---- src/cbbse_pkg.sv ----
// cbbse_pkg: constants, register map and encodings of the execution block
// assumes nothing beyond a SystemVerilog compiler
package cbbse_pkg;
  localparam int ADDR_W = 8;
  localparam int PC_W = 24;
  localparam int MEM_AW = 8;
  localparam int MEM_DEPTH = 256;
  localparam int STACK_AW = 2;
  // register byte addresses
  localparam logic [7:0] REG_INSN = 8'h00;
  localparam logic [7:0] REG_EXT = 8'h04;
  localparam logic [7:0] REG_OPND = 8'h08;
  localparam logic [7:0] REG_PC = 8'h0c;
  localparam logic [7:0] REG_CTL = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_COUNT = 8'h18;
  localparam logic [7:0] REG_SRC = 8'h1c;
  localparam logic [7:0] REG_DST = 8'h20;
  localparam logic [7:0] REG_MADDR = 8'h24;
  localparam logic [7:0] REG_MDATA = 8'h28;
  localparam logic [7:0] REG_STORE = 8'h2c;
  // flag positions in the condition code register
  localparam int C_BIT = 0;
  localparam int V_BIT = 1;
  localparam int Z_BIT = 2;
  localparam int N_BIT = 3;
  localparam int I_BIT = 7;
  // instruction fields
  localparam int OP_HI = 15;
  localparam int OP_LO = 12;
  localparam int SUB_HI = 11;
  localparam int SUB_LO = 8;
  localparam int BITNO_HI = 6;
  localparam int BITNO_LO = 4;
  localparam int SEL_EXTCTL = 8;
  localparam int WORD_FORM = 9;
  localparam int TRAP_HI = 1;
  localparam int TRAP_LO = 0;
  // status bits
  localparam int ST_BUSY = 0;
  localparam int ST_SLEEP = 1;
  localparam int ST_TAKEN = 2;
  // lengths and reset values
  localparam logic [23:0] UNIT_BYTES = 24'h000002;
  localparam logic [23:0] EXT_BYTES = 24'h000006;
  localparam logic [7:0] TRAP_VEC_BASE = 8'h20;
  localparam logic [7:0] FLAGS_RESET = 8'h80;
  localparam logic [7:0] EXTCTL_RESET = 8'h07;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // operation field codes
  localparam logic [3:0] OP_NOP = 4'h0;
  localparam logic [3:0] OP_BIT = 4'h1;
  localparam logic [3:0] OP_BRANCH = 4'h2;
  localparam logic [3:0] OP_JUMP = 4'h3;
  localparam logic [3:0] OP_RCALL = 4'h4;
  localparam logic [3:0] OP_ACALL = 4'h5;
  localparam logic [3:0] OP_RET = 4'h6;
  localparam logic [3:0] OP_TRAP = 4'h7;
  localparam logic [3:0] OP_ERET = 4'h8;
  localparam logic [3:0] OP_SLEEP = 4'h9;
  localparam logic [3:0] OP_LDCTL = 4'ha;
  localparam logic [3:0] OP_STCTL = 4'hb;
  localparam logic [3:0] OP_ANDCTL = 4'hc;
  localparam logic [3:0] OP_ORCTL = 4'hd;
  localparam logic [3:0] OP_XORCTL = 4'he;
  localparam logic [3:0] OP_COPY = 4'hf;
  // second operation field of the bit group
  localparam logic [3:0] carry_xor_bit_op = 4'h0;
  localparam logic [3:0] carry_xor_inv_bit_op = 4'h1;
  localparam logic [3:0] bit_to_carry_op = 4'h2;
  localparam logic [3:0] inv_bit_to_carry_op = 4'h3;
  localparam logic [3:0] carry_to_bit_op = 4'h4;
  localparam logic [3:0] inv_carry_to_bit_op = 4'h5;
  typedef enum logic [1:0] {ST_IDLE, ST_COPY, ST_SLEEPING} cbbse_state_e;
endpackage

// ---- sim/cbbse_checker.sv ----
// cbbse_checker: bus timing checks on the execution block ports
// bound to cbbse_top from the bench top file; one clock domain
`timescale 1ns/1ns
`default_nettype none
module cbbse_checker
  import cbbse_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  // read
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_b_hold: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  a_r_hold: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read data dropped");
  a_b_time: assert property (
    awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid)
    else $error("write response late");
  a_r_time: assert property (
    arvalid && arready |=> rvalid)
    else $error("read data late");
  a_aw_block: assert property (
    bvalid |-> !awready && !wready)
    else $error("write taken while response pending");
  a_ar_block: assert property (
    rvalid |-> !arready)
    else $error("read taken while data pending");
  a_bad_read: assert property (
    rvalid && rresp == RESP_SLVERR |-> rdata == 32'h0)
    else $error("refused read returned data");
  a_resp_code: assert property (
    bvalid |-> bresp == RESP_OKAY || bresp == RESP_SLVERR)
    else $error("bad write response code");
  a_rst_quiet: assert property (disable iff (1'b0)
    !aresetn |=> !bvalid && !rvalid && !awready && !arready)
    else $error("bus active after reset");
endmodule
`default_nettype wire

// ---- sim/cbbse_host.sv ----
// cbbse_host: AXI4-Lite master standing in for software
// tasks are called after a rising edge; hung flags a wait that ran out
`timescale 1ns/1ns
`default_nettype none
module cbbse_host
  import cbbse_pkg::*;
(
  // clock
  input wire logic aclk,
  // write
  output logic [ADDR_W-1:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  // read
  output logic [ADDR_W-1:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready,
  // status
  output logic hung
);
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, hung} = 6'h0;
    awaddr = 8'h0;
    araddr = 8'h0;
    wdata = 32'h0;
    wstrb = 4'hf;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic [2:0] p;
    int n;
    p = 3'h7;
    n = 0;
    r = 2'h3;
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= p;
    while (p != 3'h0 && n < 200) begin
      @(posedge aclk);
      n++;
      if (p[2] && awready) p[2] = 1'b0;
      if (p[1] && wready) p[1] = 1'b0;
      if (p[2:1] == 2'h0 && bvalid) begin
        p[0] = 1'b0;
        r = bresp;
      end
      {awvalid, wvalid, bready} <= p;
    end
    if (p != 3'h0) hung <= 1'b1;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic [1:0] p;
    int n;
    p = 2'h3;
    n = 0;
    d = 32'h0;
    r = 2'h3;
    araddr <= a;
    {arvalid, rready} <= p;
    while (p != 2'h0 && n < 200) begin
      @(posedge aclk);
      n++;
      if (p[1] && arready) p[1] = 1'b0;
      if (!p[1] && rvalid) begin
        p[0] = 1'b0;
        d = rdata;
        r = rresp;
      end
      {arvalid, rready} <= p;
    end
    if (p != 2'h0) hung <= 1'b1;
    @(posedge aclk);
  endtask
endmodule
`default_nettype wire

// ---- sim/tb_top.sv ----
// tb_top: runs instruction sequences through the register bus
// assumes cbbse_host as master; checker bound at the foot
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import cbbse_pkg::*;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, hung, nc;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [7:0] cr, op;
  int mismatches, comparisons;
  cbbse_host h (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .hung(hung));
  cbbse_top dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready));
  task automatic finish_test;
    if (mismatches == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, g);
    comparisons++;
    if (g !== e || hung !== 1'b0) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", s, e, g);
    end
    if (hung !== 1'b0) finish_test();
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] v,
                   input logic [1:0] e = RESP_OKAY);
    logic [1:0] rr;
    h.wr(a, v, rr);
    chk($sformatf("bresp %h", a), {30'h0, e}, {30'h0, rr});
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m = 32'hffffffff);
    logic [31:0] v;
    logic [1:0] rr;
    h.rd(a, v, rr);
    chk($sformatf("reg %h", a), e, v & m);
  endtask
  task automatic ex(input logic [15:0] i);
    w(REG_INSN, {16'h0, i});
  endtask
  task automatic mw(input logic [7:0] a, input logic [7:0] v);
    w(REG_MADDR, {24'h0, a});
    w(REG_MDATA, {24'h0, v});
  endtask
  function automatic logic cond(input logic [3:0] cc, f);
    logic x;
    x = f[3] ^ f[1];
    case (cc[3:1])
      3'h0: cond = 1'b1;
      3'h1: cond = !(f[0] | f[2]);
      3'h2: cond = !f[0];
      3'h3: cond = !f[2];
      3'h4: cond = !f[1];
      3'h5: cond = !f[3];
      3'h6: cond = !x;
      default: cond = !(f[2] | x);
    endcase
    cond = cond ^ cc[0];
  endfunction
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  initial begin
    mismatches = 0;
    comparisons = 0;
    aresetn = 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rc(REG_CTL, 32'h0780);
    rc(REG_PC, 32'h0);
    w(REG_EXT, 32'h100);
    for (int f = 0; f < 16; f++)
      for (int c = 0; c < 16; c++) begin
        w(REG_CTL, {24'h07, 4'h0, f[3:0]});
        w(REG_PC, 32'h0);
        ex({OP_BRANCH, c[3:0], 8'h0});
        rc(REG_PC, cond(c[3:0], f[3:0]) ? 32'h100 : 32'h6);
        rc(REG_STATUS, cond(c[3:0], f[3:0]) ? 32'h4 : 32'h0, 32'h4);
      end
    for (int s = 0; s < 6; s++)
      for (int k = 0; k < 4; k++) begin
        w(REG_OPND, 32'ha5);
        w(REG_CTL, {24'h07, 7'h0, k[0]});
        ex({OP_BIT, s[3:0], 2'h0, k[1], ~k[1], 4'h0});
        op = 8'ha5;
        nc = s == 0 ? k[0] ^ k[1] : s == 1 ? k[0] ^ !k[1] :
             s == 2 ? k[1] : s == 3 ? !k[1] : k[0];
        if (s > 3) op[1 + k[1]] = (s == 4) ? k[0] : !k[0];
        rc(REG_CTL, {24'h07, 7'h0, nc});
        rc(REG_OPND, {24'h0, op});
      end
    w(REG_EXT, 32'h5a);
    ex({OP_LDCTL, 12'h0});
    w(REG_EXT, 32'hc300);
    ex({OP_LDCTL, 4'h3, 8'h0});
    rc(REG_CTL, 32'hc35a);
    w(REG_EXT, 32'h3c);
    ex({OP_LDCTL, 4'h1, 8'h0});
    rc(REG_CTL, 32'h3c5a);
    ex({OP_STCTL, 4'h2, 8'h0});
    rc(REG_STORE, 32'h5a00);
    ex({OP_STCTL, 4'h1, 8'h0});
    rc(REG_STORE, 32'h3c);
    w(REG_EXT, 32'h0f);
    cr = 8'h5a;
    for (int i = 0; i < 3; i++) begin
      ex({OP_ANDCTL + i[3:0], 12'h0});
      cr = i == 0 ? cr & 8'h0f : i == 1 ? cr | 8'h0f : cr ^ 8'h0f;
      rc(REG_CTL, {16'h0, 8'h3c, cr});
    end
    ex({OP_ORCTL, 4'h1, 8'h0});
    rc(REG_CTL, {16'h0, 8'h3f, cr});
    w(REG_PC, 32'h20);
    ex(16'h0);
    rc(REG_PC, 32'h22);
    rc(REG_CTL, {16'h0, 8'h3f, cr});
    w(REG_PC, 32'h10);
    w(REG_EXT, 32'h40);
    ex({OP_ACALL, 12'h0});
    rc(REG_PC, 32'h40);
    ex({OP_RCALL, 12'h0});
    rc(REG_PC, 32'h86);
    ex({OP_RET, 12'h0});
    rc(REG_PC, 32'h46);
    ex({OP_RET, 12'h0});
    rc(REG_PC, 32'h16);
    w(REG_EXT, 32'h1234);
    ex({OP_JUMP, 12'h0});
    rc(REG_PC, 32'h1234);
    for (int i = 0; i < 3; i++) mw(8'h25 + i[7:0], i == 1 ? 8'h02 : 8'h00);
    w(REG_PC, 32'h30);
    ex({OP_TRAP, 12'h1});
    rc(REG_PC, 32'h200);
    rc(REG_CTL, 32'h3f80);
    w(REG_CTL, 32'h0105);
    ex({OP_ERET, 12'h0});
    rc(REG_PC, 32'h32);
    rc(REG_CTL, 32'h3f00);
    ex({OP_SLEEP, 12'h0});
    rc(REG_STATUS, 32'h2, 32'h3);
    ex(16'h0);
    rc(REG_STATUS, 32'h0, 32'h3);
    for (int i = 0; i < 16; i++) mw(8'h40 + i[7:0], {i[3:0], ~i[3:0]});
    w(REG_SRC, 32'h40);
    w(REG_DST, 32'h80);
    w(REG_COUNT, 32'h0210);
    ex({OP_COPY, 12'h0});
    w(REG_PC, 32'h0, RESP_SLVERR);
    d = 32'h1;
    for (int n = 0; n < 100 && d[0] !== 1'b0; n++) h.rd(REG_STATUS, d, r);
    chk("busy", 32'h0, {31'h0, d[0]});
    rc(REG_SRC, 32'h50);
    rc(REG_DST, 32'h90);
    rc(REG_COUNT, 32'h0200);
    for (int i = 0; i < 16; i++) begin
      w(REG_MADDR, 32'h80 + i);
      rc(REG_MDATA, {24'h0, i[3:0], ~i[3:0]});
    end
    ex({OP_COPY, 12'h0});
    rc(REG_STATUS, 32'h0, 32'h1);
    rc(REG_SRC, 32'h50);
    w(REG_COUNT, 32'h0002);
    ex({OP_COPY, 4'h1, 8'h0});
    repeat (8) @(posedge aclk);
    rc(REG_SRC, 32'h52);
    rc(REG_COUNT, 32'h0);
    h.rd(8'h40, d, r);
    chk("unmapped rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
    chk("unmapped rdata", 32'h0, d);
    w(REG_STATUS, 32'h1, RESP_SLVERR);
    finish_test();
  end
endmodule
bind cbbse_top cbbse_checker chk_i (.aclk(aclk), .aresetn(aresetn),
  .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
  .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
  .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
  .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
  .rready(rready));
`default_nettype wire
